// [design/dmsb_aux_ram.sv]
// on-chip auxiliary ram reached by external-move accesses
`timescale 1ns/1ns
`default_nettype none
module dmsb_aux_ram #(
   parameter int DEPTH = 1024,
   parameter int AW    = 10
) (
   input  wire logic          clk,
   input  wire logic          rst_n,
   input  wire logic          we,
   input  wire logic          re,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic [7:0]         rdata,
   output logic               ack
);
   logic [7:0] mem [DEPTH];

   // byte storage, one access per cycle
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      if (re) begin
         rdata <= mem[addr];
      end
   end

   // acknowledge one cycle after the request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ack <= 1'b0;
      end else begin
         ack <= we | re;
      end
   end
endmodule // dmsb_aux_ram
`default_nettype wire

// [design/dmsb_map.svh]
// constants for the data-memory space and external bus block
`ifndef DMSB_MAP_SVH
`define DMSB_MAP_SVH
`define DMSB_AUX_LAST      16'h03ff
`define DMSB_AUX_DEPTH     1024
`define DMSB_LOWER_LAST    8'h7f
`define DMSB_P0_FLOAT      8'hff
`define DMSB_P0_RESET      8'hff
`define DMSB_P2_RESET      8'hff
`define DMSB_AUX_SEL_RESET 1'b1
`define DMSB_ADDR_CYC      2
`define DMSB_STROBE_CYC    3
`endif

// [design/dmsb_pkg.sv]
// types for the data-memory space and external bus block
package dmsb_pkg;
   typedef enum logic [1:0] {
      DMSB_IND_LOW = 2'b00,
      DMSB_IND_UP  = 2'b01,
      DMSB_DIR_LOW = 2'b10,
      DMSB_DIR_SFR = 2'b11
   } dmsb_space_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        wide;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } dmsb_xreq_t;

   typedef struct packed {
      logic       done;
      logic [7:0] rdata;
   } dmsb_xrsp_t;

   typedef struct packed {
      logic       indirect;
      logic [7:0] addr;
   } dmsb_ireq_t;

   typedef struct packed {
      dmsb_space_t space;
      logic        bit_ok;
      logic        reserved;
      logic [6:0]  offset;
   } dmsb_idec_t;
endpackage : dmsb_pkg

// [design/dmsb_top.sv]
// data-memory address decoding and external data-memory bus
// Contract
// - 1024 bytes of auxiliary ram at 000H-3FFH, reached by wide external moves only
// - select bit cleared sends 000H-3FFH external moves to external memory
// - external access uses 16-bit pointer address or 8-bit index address
// - wide access outside the aux ram drives port 0, port 2, read and write strobes as bus
// - narrow access leaves port 2 as general-purpose output
// - low address and data share port 0 in time
// - low address valid on port 0 at latch strobe falling edge
// - write data placed before write strobe and held after release
// - read data sampled just before read strobe is released; code takes the port 0 pin level from two edges before release, via p0_s2_q
// - any external bus access loads 0FFH into the port 0 latch; aux ram accesses leave it
// - special registers at 80H-FFH, direct addressing only
// - only special registers ending 0H or 8H are bit-addressable
// - lower ram up to 7FH reached directly and indirectly
// - indirect above 7FH is upper ram, direct is special registers
`timescale 1ns/1ns
`default_nettype none
`include "dmsb_map.svh"
module dmsb_top #(
   parameter int AUX_DEPTH  = `DMSB_AUX_DEPTH,
   parameter int ADDR_CYC   = `DMSB_ADDR_CYC,
   parameter int STROBE_CYC = `DMSB_STROBE_CYC
) (
   input  wire logic            clk,
   input  wire logic            rstn,
   input  wire dmsb_pkg::dmsb_xreq_t xreq,
   output var  dmsb_pkg::dmsb_xrsp_t xrsp,
   input  wire logic            aux_sel_wr,
   input  wire logic            aux_sel_val,
   output logic                 aux_ram_select_bit,
   input  wire logic            p0_latch_wr,
   input  wire logic [7:0]      p0_latch_val,
   output logic [7:0]           p0_latch,
   input  wire logic [7:0]      p2_gpio_out,
   input  wire dmsb_pkg::dmsb_ireq_t ireq,
   output var  dmsb_pkg::dmsb_idec_t idec,
   output logic                 xbusy,
   input  wire logic [7:0]      p0_in,
   output logic [7:0]           p0_out,
   output logic                 p0_oe,
   output logic [7:0]           p2_out,
   output logic                 ale,
   output logic                 rd_n,
   output logic                 wr_n
);
   import dmsb_pkg::*;

   typedef enum logic [2:0] {
      DMSB_IDLE  = 3'b000,
      DMSB_ADDR  = 3'b001,
      DMSB_SETUP = 3'b010,
      DMSB_STRB  = 3'b011,
      DMSB_HOLD  = 3'b100,
      DMSB_AUX   = 3'b101
   } dmsb_state_t;

   localparam int AW = $clog2(AUX_DEPTH);

   logic        rst_s1_q;
   logic        rst_n_q;
   logic [7:0]  p0_s1_q;
   logic [7:0]  p0_s2_q;
   dmsb_state_t state_q;
   logic [3:0]  cnt_q;
   dmsb_xreq_t  req_q;
   logic        aux_we;
   logic        aux_re;
   logic [7:0]  aux_rdata;
   logic        aux_ack;
   logic        go_aux;
   logic        go_ext;
   logic        addr_end;
   logic        strb_end;

   // decode one internal-ram address by addressing mode
   function automatic dmsb_idec_t decode(input dmsb_ireq_t r);
      dmsb_idec_t d;
      d.offset = r.addr[6:0];
      if (r.addr <= `DMSB_LOWER_LAST) begin
         d.space = r.indirect ? DMSB_IND_LOW : DMSB_DIR_LOW;
      end else begin
         d.space = r.indirect ? DMSB_IND_UP : DMSB_DIR_SFR;
      end
      d.bit_ok   = (d.space == DMSB_DIR_SFR) && (r.addr[2:0] == 3'h0);
      d.reserved = 1'b0;
      return d;
   endfunction

   // wide external moves in the low 1k go on chip while the select bit is set
   function automatic logic is_aux(input dmsb_xreq_t r, input logic sel);
      return sel && r.wide && (r.addr <= `DMSB_AUX_LAST);
   endfunction

   // true in the last cycle of a phase that lasts n cycles
   function automatic logic last_cyc(input logic [3:0] c, input int n);
      return c == 4'(n - 1);
   endfunction

   // reset release through two flip-flops
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   // port 0 pins come from outside, two stages before use
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         p0_s1_q <= 8'h00;
         p0_s2_q <= 8'h00;
      end else begin
         p0_s1_q <= p0_in;
         p0_s2_q <= p0_s1_q;
      end
   end

   // auxiliary ram select bit of the chip control register
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         aux_ram_select_bit <= `DMSB_AUX_SEL_RESET;
      end else if (aux_sel_wr) begin
         aux_ram_select_bit <= aux_sel_val;
      end
   end

   // request routing and phase ends
   assign go_aux = (state_q == DMSB_IDLE) && xreq.valid && is_aux(xreq, aux_ram_select_bit);
   assign go_ext   = (state_q == DMSB_IDLE) && xreq.valid && !go_aux;
   assign addr_end = (state_q == DMSB_ADDR) && last_cyc(cnt_q, ADDR_CYC);
   assign strb_end = (state_q == DMSB_STRB) && last_cyc(cnt_q, STROBE_CYC);
   assign aux_we = go_aux && xreq.write;
   assign aux_re = go_aux && !xreq.write;

   dmsb_aux_ram #(
      .DEPTH (AUX_DEPTH),
      .AW    (AW)
   ) u_aux (
      .clk   (clk),
      .rst_n (rst_n_q),
      .we    (aux_we),
      .re    (aux_re),
      .addr  (xreq.addr[AW-1:0]),
      .wdata (xreq.wdata),
      .rdata (aux_rdata),
      .ack   (aux_ack)
   );

   // access sequencer and cycle counter
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= DMSB_IDLE;
         cnt_q   <= 4'h0;
         req_q   <= '0;
      end else begin
         unique case (state_q)
            DMSB_IDLE: begin
               if (xreq.valid) begin
                  req_q <= xreq;
                  cnt_q <= 4'h0;
                  state_q <= go_aux ? DMSB_AUX : DMSB_ADDR;
               end
            end
            DMSB_ADDR: begin
               if (addr_end) begin
                  state_q <= DMSB_SETUP;
                  cnt_q   <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            DMSB_SETUP: begin
               state_q <= DMSB_STRB;
            end
            DMSB_STRB: begin
               if (strb_end) begin
                  state_q <= DMSB_HOLD;
                  cnt_q   <= 4'h0;
               end else begin
                  cnt_q <= cnt_q + 4'h1;
               end
            end
            DMSB_HOLD: begin
               state_q <= DMSB_IDLE;
            end
            DMSB_AUX: begin
               state_q <= DMSB_IDLE;
            end
            default: begin
               state_q <= DMSB_IDLE;
            end
         endcase
      end
   end

   // port 0 drive: address, then write data, released for reads
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         p0_out <= `DMSB_P0_FLOAT;
         p0_oe  <= 1'b0;
      end else if (go_ext) begin
         p0_out <= xreq.addr[7:0];
         p0_oe  <= 1'b1;
      end else if (addr_end) begin
         p0_out <= req_q.wdata;
         p0_oe  <= req_q.write;
      end else if (state_q == DMSB_HOLD || state_q == DMSB_IDLE) begin
         p0_out <= `DMSB_P0_FLOAT;
         p0_oe  <= 1'b0;
      end
   end

   // address latch strobe high during the address phase only
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         ale <= 1'b0;
      end else if (go_ext) begin
         ale <= 1'b1;
      end else if (addr_end) begin
         ale <= 1'b0;
      end
   end

   // port 2 carries the high address only in wide accesses
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         p2_out <= `DMSB_P2_RESET;
      end else if (go_ext && xreq.wide) begin
         p2_out <= xreq.addr[15:8];
      end else if (state_q == DMSB_IDLE) begin
         p2_out <= p2_gpio_out;
      end else if (!req_q.wide) begin
         p2_out <= p2_gpio_out;
      end
   end

   // strobes active low during the strobe phase, write after data setup
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rd_n <= 1'b1;
         wr_n <= 1'b1;
      end else if (state_q == DMSB_SETUP) begin
         rd_n <= req_q.write;
         wr_n <= !req_q.write;
      end else if (strb_end) begin
         rd_n <= 1'b1;
         wr_n <= 1'b1;
      end
   end

   // completion and read data, sampled in the last strobe cycle or on the aux ram acknowledge
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         xrsp <= '0;
      end else if (strb_end) begin
         xrsp.done  <= 1'b1;
         xrsp.rdata <= req_q.write ? 8'h00 : p0_s2_q;
      end else if (aux_ack) begin
         xrsp.done  <= 1'b1;
         xrsp.rdata <= req_q.write ? 8'h00 : aux_rdata;
      end else begin
         xrsp.done <= 1'b0;
      end
   end

   // port 0 latch: software writes, external bus access forces all ones
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         p0_latch <= `DMSB_P0_RESET;
      end else if (state_q == DMSB_ADDR) begin
         p0_latch <= `DMSB_P0_FLOAT;
      end else if (p0_latch_wr) begin
         p0_latch <= p0_latch_val;
      end
   end

   // busy from the accepting edge until the access ends
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         xbusy <= 1'b0;
      end else if (state_q == DMSB_IDLE) begin
         xbusy <= xreq.valid;
      end else begin
         xbusy <= (state_q != DMSB_HOLD) && (state_q != DMSB_AUX);
      end
   end

   // registered internal-ram decode
   always_ff @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         idec <= '0;
      end else begin
         idec <= decode(ireq);
      end
   end
endmodule // dmsb_top
`default_nettype wire

// [testbench/dmsb_top_properties.sv]
// bus timing checker for dmsb_top
`timescale 1ns/1ns
`default_nettype none
module dmsb_top_properties #(
   parameter int ADDR_CYC   = 2,
   parameter int STROBE_CYC = 3
) (
   input wire logic                 clk,
   input wire logic                 rstn,
   input wire dmsb_pkg::dmsb_xrsp_t xrsp,
   input wire logic                 xbusy,
   input wire logic [7:0]           p0_out,
   input wire logic                 p0_oe,
   input wire logic [7:0]           p0_latch,
   input wire logic                 ale,
   input wire logic                 rd_n,
   input wire logic                 wr_n
);
   import dmsb_pkg::*;
   logic [3:0] ale_n_q;
   logic [3:0] stb_n_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // cycles the latch strobe and the strobes have stood
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ale_n_q <= 4'h0;
         stb_n_q <= 4'h0;
      end else begin
         ale_n_q <= ale ? ale_n_q + 4'h1 : 4'h0;
         stb_n_q <= (!rd_n || !wr_n) ? stb_n_q + 4'h1 : 4'h0;
      end
   end
   ale_width_a: assert property ($fell(ale) |-> ale_n_q == ADDR_CYC)
      else $error("latch strobe width");
   addr_hold_a: assert property ($rose(ale) |=> p0_oe && $stable(p0_out))
      else $error("address moved under latch strobe");
   ale_drive_a: assert property (ale |-> p0_oe && rd_n && wr_n)
      else $error("port 0 not driving address");
   p0_cleared_a: assert property ($rose(ale) |=> p0_latch == 8'hff)
      else $error("port 0 latch not cleared");
   wr_data_a: assert property (!wr_n |=> p0_oe && $stable(p0_out))
      else $error("write data not held");
   rd_float_a: assert property (!rd_n |-> !p0_oe)
      else $error("port 0 driven in read");
   stb_width_a: assert property ($rose(rd_n) || $rose(wr_n) |-> stb_n_q == STROBE_CYC && xrsp.done)
      else $error("strobe width or done");
   strobe_excl_a: assert property (rd_n || wr_n)
      else $error("both strobes low");
   aux_quiet_a: assert property ($rose(xbusy) && !ale |-> (!ale && rd_n && wr_n && !p0_oe) [*2])
      else $error("bus moved in aux access");
   // main traffic kinds
   cover property ($fell(wr_n));
   cover property ($fell(rd_n));
   cover property ($rose(xbusy) && !ale);
endmodule // dmsb_top_properties
bind dmsb_top dmsb_top_properties #(.ADDR_CYC(ADDR_CYC), .STROBE_CYC(STROBE_CYC)) i_props (
   .clk, .rstn, .xrsp, .xbusy, .p0_out, .p0_oe, .p0_latch, .ale, .rd_n, .wr_n);
`default_nettype wire

// [testbench/dmsb_xmem_model.sv]
// external ram behind a transparent address latch
`timescale 1ns/1ns
`default_nettype none
module dmsb_xmem_model (
   input  wire logic       clk,
   input  wire logic [7:0] p0_out,
   input  wire logic       p0_oe,
   input  wire logic [7:0] p2_out,
   input  wire logic       ale,
   input  wire logic       rd_n,
   input  wire logic       wr_n,
   output logic [7:0]      p0_in
);
   logic [7:0] mem [0:65535];
   logic [7:0] lo_q;
   logic [7:0] last_q = 8'h00;
   // port 0 level: device, ram while read strobe low, else toggling float
   assign p0_in = p0_oe ? p0_out : (!rd_n ? mem[{p2_out, lo_q}] : ~last_q);
   // latch follows port 0 while strobe high, holds from its fall
   always @(posedge clk) begin
      if (ale) lo_q <= p0_in;
      last_q <= p0_in;
   end
   // write lands on the rising write strobe
   always @(posedge wr_n) mem[{p2_out, lo_q}] <= p0_in;
endmodule // dmsb_xmem_model
`default_nettype wire

// [testbench/test_data_memory_space_and_external_bus.sv]
// self-checking bench for dmsb_top
`timescale 1ns/1ns
`default_nettype none
module test_data_memory_space_and_external_bus;
   import dmsb_pkg::*;
   localparam int AC  = 2;
   localparam int SC  = 3;
   localparam int EXT = AC + SC + 2;
   localparam int AUX = 2;
   logic       clk = 1'b0, rstn, aux_sel_wr, aux_sel_val, aux_ram_select_bit;
   logic       p0_latch_wr, xbusy, p0_oe, ale, rd_n, wr_n;
   logic [7:0] p0_latch_val, p0_latch, p2_gpio_out, p0_in, p0_out, p2_out, rd, p2s;
   dmsb_xreq_t xreq;
   dmsb_xrsp_t xrsp;
   dmsb_ireq_t ireq;
   dmsb_idec_t idec;
   int         fail_count = 0, comparisons = 0, cycles = 0;
   dmsb_top #(.ADDR_CYC(AC), .STROBE_CYC(SC)) i_dut (.clk, .rstn, .xreq, .xrsp, .aux_sel_wr, .aux_sel_val,
      .aux_ram_select_bit, .p0_latch_wr, .p0_latch_val, .p0_latch, .p2_gpio_out, .ireq, .idec, .xbusy,
      .p0_in, .p0_out, .p0_oe, .p2_out, .ale, .rd_n, .wr_n);
   dmsb_xmem_model i_mem (.clk, .p0_out, .p0_oe, .p2_out, .ale, .rd_n, .wr_n, .p0_in);
   // clock and hang limit
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cycles++;
      if (cycles > 3000) begin
         fail_count++;
         results();
      end
   end
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fail_count++;
      end
   endtask
   // one access: request held for the take edge only, then wait for done
   task automatic xfer(logic w, logic wd, logic [15:0] a, logic [7:0] d, int lat);
      int n;
      n = 0;
      p2s = 8'h00;
      xreq = '{1'b1, w, wd, a, d};
      do begin
         @(negedge clk);
         n++;
         xreq.valid = 1'b0;
         if (n == 1) chk("busy", 16'h1, 16'(xbusy));
         if (!rd_n || !wr_n) p2s = p2_out;
      end while (xrsp.done !== 1'b1 && n < 20);
      rd = xrsp.rdata;
      chk("latency", 16'(lat), 16'(n));
      @(negedge clk);
      chk("idle", 16'h0, 16'(xbusy));
   endtask
   task automatic sel(logic v);
      aux_sel_wr = 1'b1;
      aux_sel_val = v;
      @(negedge clk);
      aux_sel_wr = 1'b0;
   endtask
   // wide and narrow external traffic
   task automatic t_ext();
      p0_latch_wr = 1'b1;
      p0_latch_val = 8'h5a;
      @(negedge clk);
      p0_latch_wr = 1'b0;
      xfer(1'b1, 1'b1, 16'h1234, 8'ha5, EXT);
      chk("p2 address", 16'h12, p2s);
      chk("ram byte", 16'ha5, i_mem.mem[16'h1234]);
      chk("p0 latch", 16'hff, p0_latch);
      xfer(1'b0, 1'b1, 16'h1234, 8'h00, EXT);
      chk("read", 16'ha5, rd);
      p2_gpio_out = 8'h03;
      xfer(1'b1, 1'b0, 16'h0056, 8'h3c, EXT);
      chk("p2 gpio", 16'h03, p2s);
      chk("paged byte", 16'h3c, i_mem.mem[16'h0356]);
      xfer(1'b0, 1'b0, 16'h0056, 8'h00, EXT);
      chk("paged read", 16'h3c, rd);
   endtask
   // aux ram boundary and select bit
   task automatic t_aux();
      xfer(1'b1, 1'b1, 16'h03ff, 8'h77, AUX);
      xfer(1'b1, 1'b1, 16'h0400, 8'h88, EXT);
      chk("above aux", 16'h88, i_mem.mem[16'h0400]);
      sel(1'b0);
      chk("select bit", 16'h0, aux_ram_select_bit);
      xfer(1'b1, 1'b1, 16'h03ff, 8'h99, EXT);
      chk("ext at 3ff", 16'h99, i_mem.mem[16'h03ff]);
      sel(1'b1);
      xfer(1'b0, 1'b1, 16'h03ff, 8'h00, AUX);
      chk("aux read", 16'h77, rd);
   endtask
   // internal address decode
   task automatic t_decode();
      logic [7:0] al [6] = '{8'h00, 8'h7f, 8'h80, 8'h88, 8'h8f, 8'hff};
      dmsb_idec_t e;
      for (int i = 0; i < 12; i++) begin
         ireq = '{i[0], al[i/2]};
         e = '{dmsb_space_t'({~i[0], al[i/2][7]}), !i[0] && al[i/2][7] && al[i/2][2:0] == 3'h0, 1'b0, al[i/2][6:0]};
         @(negedge clk);
         chk("decode", 16'(e), 16'(idec));
      end
   endtask
   task automatic results();
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // reset, then the scenarios
   initial begin
      {rstn, aux_sel_wr, aux_sel_val, p0_latch_wr, p0_latch_val, p2_gpio_out} = '0;
      xreq = '0;
      ireq = '0;
      repeat (4) @(negedge clk);
      chk("reset outs", 16'h0ff3, 16'({p0_latch, p0_oe, ale, rd_n, wr_n}));
      chk("reset bus", 16'hffff, {p0_out, p2_out});
      chk("reset idle", 16'h0, 16'({xrsp, xbusy}));
      chk("reset select", 16'h1, aux_ram_select_bit);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      t_ext();
      t_aux();
      t_decode();
      results();
   end
endmodule // test_data_memory_space_and_external_bus
`default_nettype wire
